// *** src/id_detect_vendor_regs.sv ***
// id-detect event latch and vendor registers of a hs transceiver's register space
// assumes an upstream ulpi framer presents one decoded immediate access per reg_valid_i pulse
// and sends alt_int_o out in the next rxcmd byte
`timescale 1ns/1ns

module id_detect_vendor_regs
  import id_vendor_pkg::*;
#(
  parameter int CONV_CYCLES_P = CONV_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // register access from the ulpi framer
  input wire logic reg_valid_i,
  input wire reg_req_t reg_req_i,
  output logic reg_ack_o,
  output logic [7:0] reg_rdata_o,
  // id pin and carkit enables
  input wire logic id_floating_i,
  input wire logic id_float_rise_irq_enable_i,
  input wire logic id_float_fall_irq_enable_i,
  input wire logic carkit_resistor_irq_enable_i,
  input wire logic carkit_status_read_i,
  // analog resistor converter
  input wire logic [2:0] converter_code_i,
  output logic converter_run_o,
  // controls to the analog front end
  output logic [1:0] hs_amplitude_trim_o,
  output logic [6:0] hs_boost_tenths_o,
  output logic headset_audio_en_o,
  // carkit status view and interrupt
  output res_status_t carkit_res_status_o,
  output logic alt_int_o
);

  // register state
  logic [1:0] trim_q;
  logic [3:0] headset_audio_key_field_q;
  logic [2:0] id_resistor_code_q;
  logic resistor_conversion_done_q;
  logic resistor_conversion_start_q;
  logic rconv_rsvd_q;
  logic resistor_done_irq_enable_q;
  logic id_float_event_latched_q;
  logic resistor_done_event_latched_q;
  logic done_prev_q;

  // access decode
  logic rd_req;
  logic wr_req;
  logic hit_latch;
  logic hit_trim;
  logic hit_key;
  logic hit_rconv;
  logic in_vendor;

  // conversion register write path
  logic [7:0] rconv_cur;
  logic [7:0] rconv_new;
  logic rconv_wr;

  // events
  logic id_rise;
  logic id_fall;
  logic id_event;
  logic done_rise;
  logic res_irq_en;
  logic res_event;
  logic conv_start;
  logic conv_abort;
  logic conv_busy;
  logic conv_finish;
  logic latch_read;
  logic code_read;
  logic [7:0] rdata_d;

  assign rd_req = reg_valid_i && !reg_req_i.write;
  assign wr_req = reg_valid_i && reg_req_i.write;
  assign in_vendor = reg_req_i.addr >= ADDR_VENDOR_LO && reg_req_i.addr <= ADDR_VENDOR_HI;
  assign hit_latch = reg_req_i.addr == ADDR_EVENT_LATCH;
  assign hit_trim = in_vendor && reg_req_i.addr == ADDR_AMP_TRIM;
  assign hit_key = in_vendor && reg_req_i.addr == ADDR_HEADSET_KEY;
  assign hit_rconv = in_vendor && reg_req_i.addr >= ADDR_RCONV_WR
    && reg_req_i.addr <= ADDR_RCONV_CLR;

  assign latch_read = rd_req && hit_latch;
  assign code_read = rd_req && hit_rconv;

  // current stored image of the conversion register
  always_comb begin
    rconv_cur = RESET_BYTE;
    rconv_cur[RCONV_CODE_MSB:RCONV_CODE_LSB] = id_resistor_code_q;
    rconv_cur[RCONV_START_BIT] = resistor_conversion_start_q;
    rconv_cur[RCONV_RSVD_BIT] = rconv_rsvd_q;
    rconv_cur[RCONV_IRQ_EN_BIT] = resistor_done_irq_enable_q;
  end

  // write, set and clear forms of the conversion register
  always_comb begin
    rconv_new = rconv_cur;
    rconv_wr = 1'b0;
    if (wr_req && hit_rconv) begin
      rconv_wr = 1'b1;
      case (reg_req_i.addr)
        ADDR_RCONV_WR: begin
          rconv_new = reg_req_i.wdata;
        end
        ADDR_RCONV_SET: begin
          rconv_new = rconv_cur | reg_req_i.wdata;
        end
        ADDR_RCONV_CLR: begin
          rconv_new = rconv_cur & ~reg_req_i.wdata;
        end
        default: begin
          rconv_wr = 1'b0;
        end
      endcase
    end
  end

  // start on a written or set one while idle; clearing the bit abandons the run
  assign conv_start = rconv_wr && rconv_new[RCONV_START_BIT] && !resistor_conversion_start_q;
  assign conv_abort = rconv_wr && !rconv_new[RCONV_START_BIT] && resistor_conversion_start_q;

  conv_timer #(
    .CYCLES(CONV_CYCLES_P)
  ) u_conv_timer (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .start_i(conv_start),
    .abort_i(conv_abort),
    .busy_o(conv_busy),
    .done_o(conv_finish)
  );

  edge_detect #(
    .WIDTH(1)
  ) u_id_edge (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .level_i(id_floating_i),
    .rise_o(id_rise),
    .fall_o(id_fall)
  );

  assign id_event = (id_rise && id_float_rise_irq_enable_i)
    || (id_fall && id_float_fall_irq_enable_i);
  assign res_irq_en = resistor_done_irq_enable_q || carkit_resistor_irq_enable_i;
  assign done_rise = resistor_conversion_done_q && !done_prev_q;
  assign res_event = done_rise && res_irq_en;

  // amplitude trim, plain read/write only
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      trim_q <= TRIM_NOMINAL;
    end else if (wr_req && hit_trim) begin
      trim_q <= reg_req_i.wdata[TRIM_MSB:TRIM_LSB];
    end
  end

  // headset key, plain read/write only
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      headset_audio_key_field_q <= 4'h0;
    end else if (wr_req && hit_key) begin
      headset_audio_key_field_q <= reg_req_i.wdata[3:0];
    end
  end

  // conversion register storage bits
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rconv_rsvd_q <= 1'b0;
      resistor_done_irq_enable_q <= 1'b0;
    end else if (rconv_wr) begin
      rconv_rsvd_q <= rconv_new[RCONV_RSVD_BIT];
      resistor_done_irq_enable_q <= rconv_new[RCONV_IRQ_EN_BIT];
    end
  end

  // start bit follows the run and drops on completion
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      resistor_conversion_start_q <= 1'b0;
    end else if (conv_finish) begin
      resistor_conversion_start_q <= 1'b0;
    end else if (rconv_wr) begin
      resistor_conversion_start_q <= rconv_new[RCONV_START_BIT];
    end
  end

  // code: result of the converter wins over a simultaneous write
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      id_resistor_code_q <= RCODE_0_OHM;
    end else if (conv_finish) begin
      id_resistor_code_q <= converter_code_i;
    end else if (rconv_wr) begin
      id_resistor_code_q <= rconv_new[RCONV_CODE_MSB:RCONV_CODE_LSB];
    end
  end

  // done flag: set wins over the read clear; status reads never touch it
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      resistor_conversion_done_q <= 1'b0;
      done_prev_q <= 1'b0;
    end else begin
      done_prev_q <= resistor_conversion_done_q;
      if (conv_finish) begin
        resistor_conversion_done_q <= 1'b1;
      end else if (code_read) begin
        resistor_conversion_done_q <= 1'b0;
      end
    end
  end

  // event latch: reads clear only what was returned, new events are kept
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      id_float_event_latched_q <= 1'b0;
    end else if (id_event) begin
      id_float_event_latched_q <= 1'b1;
    end else if (latch_read) begin
      id_float_event_latched_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      resistor_done_event_latched_q <= 1'b0;
    end else if (res_event) begin
      resistor_done_event_latched_q <= 1'b1;
    end else if (latch_read) begin
      resistor_done_event_latched_q <= 1'b0;
    end
  end

  // read data mux; unmapped addresses answer zero
  always_comb begin
    rdata_d = RESET_BYTE;
    if (hit_latch) begin
      rdata_d[LATCH_ID_FLOAT_BIT] = id_float_event_latched_q;
      rdata_d[LATCH_RES_DONE_BIT] = resistor_done_event_latched_q;
    end else if (hit_trim) begin
      rdata_d[TRIM_MSB:TRIM_LSB] = trim_q;
    end else if (hit_key) begin
      rdata_d[3:0] = headset_audio_key_field_q;
    end else if (hit_rconv) begin
      rdata_d = rconv_cur & RCONV_STORE_MASK;
      rdata_d[RCONV_DONE_BIT] = resistor_conversion_done_q;
    end
  end

  // register answer one cycle after the request
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      reg_ack_o <= 1'b0;
      reg_rdata_o <= RESET_BYTE;
    end else begin
      reg_ack_o <= reg_valid_i;
      if (rd_req) begin
        reg_rdata_o <= rdata_d;
      end
    end
  end

  // analog controls
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      hs_amplitude_trim_o <= TRIM_NOMINAL;
      hs_boost_tenths_o <= BOOST_NOMINAL_TENTHS;
    end else begin
      hs_amplitude_trim_o <= trim_q;
      case (trim_q)
        TRIM_NOMINAL: begin
          hs_boost_tenths_o <= BOOST_NOMINAL_TENTHS;
        end
        TRIM_PLUS_11P1: begin
          hs_boost_tenths_o <= BOOST_11P1_TENTHS;
        end
        TRIM_PLUS_7P4: begin
          hs_boost_tenths_o <= BOOST_7P4_TENTHS;
        end
        TRIM_PLUS_3P7: begin
          hs_boost_tenths_o <= BOOST_3P7_TENTHS;
        end
        default: begin
          hs_boost_tenths_o <= BOOST_NOMINAL_TENTHS;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      headset_audio_en_o <= 1'b0;
      converter_run_o <= 1'b0;
    end else begin
      headset_audio_en_o <= headset_audio_key_field_q == HEADSET_KEY_VALUE;
      converter_run_o <= conv_busy;
    end
  end

  // carkit status mirror; its read strobe is deliberately unused for clearing
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      carkit_res_status_o <= '0;
    end else begin
      carkit_res_status_o.done <= resistor_conversion_done_q;
      carkit_res_status_o.code <= id_resistor_code_q;
    end
  end

  // one-cycle interrupt pulse toward the rxcmd builder
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      alt_int_o <= 1'b0;
    end else begin
      alt_int_o <= id_event || res_event;
    end
  end

  logic unused_status_read;
  assign unused_status_read = carkit_status_read_i;

endmodule : id_detect_vendor_regs

// *** shared/id_vendor_pkg.sv ***
// register map, field positions and timing for the id-detect and vendor register bank
// assumes a 50 MHz register clock and an upstream ulpi framer that decodes immediate accesses
package id_vendor_pkg;

  // register addresses (6-bit ulpi immediate address space)
  localparam logic [5:0] ADDR_EVENT_LATCH = 6'h21;
  localparam logic [5:0] ADDR_VENDOR_LO = 6'h30;
  localparam logic [5:0] ADDR_VENDOR_HI = 6'h3F;
  localparam logic [5:0] ADDR_AMP_TRIM = 6'h31;
  localparam logic [5:0] ADDR_HEADSET_KEY = 6'h33;
  localparam logic [5:0] ADDR_RCONV_WR = 6'h36;
  localparam logic [5:0] ADDR_RCONV_SET = 6'h37;
  localparam logic [5:0] ADDR_RCONV_CLR = 6'h38;

  // event latch fields
  localparam int LATCH_ID_FLOAT_BIT = 0;
  localparam int LATCH_RES_DONE_BIT = 3;

  // amplitude trim field
  localparam int TRIM_LSB = 5;
  localparam int TRIM_MSB = 6;
  localparam logic [1:0] TRIM_NOMINAL = 2'h0;
  localparam logic [1:0] TRIM_PLUS_11P1 = 2'h1;
  localparam logic [1:0] TRIM_PLUS_7P4 = 2'h2;
  localparam logic [1:0] TRIM_PLUS_3P7 = 2'h3;
  // drive increase in tenths of a percent
  localparam logic [6:0] BOOST_NOMINAL_TENTHS = 7'h00;
  localparam logic [6:0] BOOST_11P1_TENTHS = 7'h6F;
  localparam logic [6:0] BOOST_7P4_TENTHS = 7'h4A;
  localparam logic [6:0] BOOST_3P7_TENTHS = 7'h25;

  // headset audio key
  localparam logic [3:0] HEADSET_KEY_VALUE = 4'hA;

  // resistor conversion register fields
  localparam int RCONV_CODE_LSB = 0;
  localparam int RCONV_CODE_MSB = 2;
  localparam int RCONV_DONE_BIT = 3;
  localparam int RCONV_START_BIT = 4;
  localparam int RCONV_RSVD_BIT = 5;
  localparam int RCONV_IRQ_EN_BIT = 6;
  // bits held as storage: code, start, reserved, irq enable
  localparam logic [7:0] RCONV_STORE_MASK = 8'h77;

  // resistor codes
  localparam logic [2:0] RCODE_0_OHM = 3'h0;
  localparam logic [2:0] RCODE_75_OHM = 3'h1;
  localparam logic [2:0] RCODE_100K = 3'h2;
  localparam logic [2:0] RCODE_200K = 3'h3;
  localparam logic [2:0] RCODE_440K = 3'h4;
  localparam logic [2:0] RCODE_FLOATING = 3'h5;
  localparam logic [2:0] RCODE_ERROR = 3'h7;

  // reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // conversion timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int CONV_TIME_NS = 282000;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register access request from the ulpi framer
  typedef struct packed {
    logic write;
    logic [5:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // carkit status view of the conversion result
  typedef struct packed {
    logic done;
    logic [2:0] code;
  } res_status_t;

endpackage : id_vendor_pkg

// *** src/conv_timer.sv ***
// conversion timer: counts a fixed number of cycles after a start pulse
// assumes start and abort are single-cycle requests in the register clock domain
`timescale 1ns/1ns
module conv_timer #(
  parameter int CYCLES = 14100
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic start_i,
  input wire logic abort_i,
  // status
  output logic busy_o,
  output logic done_o
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] count_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      busy_o <= 1'b0;
      count_q <= '0;
    end else if (abort_i) begin
      busy_o <= 1'b0;
      count_q <= '0;
    end else if (start_i && !busy_o) begin
      busy_o <= 1'b1;
      count_q <= '0;
    end else if (busy_o) begin
      if (count_q == LAST) begin
        busy_o <= 1'b0;
      end
      count_q <= count_q + 1'b1;
    end
  end

  // one-cycle pulse in the cycle after the final counted cycle
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      done_o <= 1'b0;
    end else begin
      done_o <= busy_o && !abort_i && count_q == LAST;
    end
  end

endmodule : conv_timer

// *** src/edge_detect.sv ***
// per-bit rise and fall detection of level inputs
// assumes inputs are already synchronous to clk_i
`timescale 1ns/1ns
module edge_detect #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // levels
  input wire logic [WIDTH-1:0] level_i,
  // edges
  output logic [WIDTH-1:0] rise_o,
  output logic [WIDTH-1:0] fall_o
);

  logic [WIDTH-1:0] prev_q;
  logic armed_q;

  // first cycle after reset only captures, never reports
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      armed_q <= 1'b0;
    end else begin
      armed_q <= 1'b1;
    end
  end

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        prev_q[i] <= 1'b0;
      end else begin
        prev_q[i] <= level_i[i];
      end
    end
    assign rise_o[i] = armed_q && level_i[i] && !prev_q[i];
    assign fall_o[i] = armed_q && !level_i[i] && prev_q[i];
  end

endmodule : edge_detect

// *** verif/id_vendor_props.sv ***
// checker for the id-detect and vendor register bank
// assumes it is bound to id_detect_vendor_regs and sees only its ports
`timescale 1ns/1ns
module id_vendor_props
  import id_vendor_pkg::*;
#(
  parameter int CONV_CYCLES_P = CONV_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // register bus
  input wire logic reg_valid_i,
  input wire reg_req_t reg_req_i,
  input wire logic reg_ack_o,
  input wire logic [7:0] reg_rdata_o,
  // pins and status
  input wire logic id_floating_i,
  input wire logic id_float_rise_irq_enable_i,
  input wire logic carkit_status_read_i,
  input wire logic converter_run_o,
  input wire logic [1:0] hs_amplitude_trim_o,
  input wire logic [6:0] hs_boost_tenths_o,
  input wire logic headset_audio_en_o,
  input wire res_status_t carkit_res_status_o,
  input wire logic alt_int_o
);
  int run_cnt_q;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // length of the current run
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !converter_run_o) begin
      run_cnt_q <= 0;
    end else begin
      run_cnt_q <= run_cnt_q + 1;
    end
  end
  sequence rd_s(a);
    reg_valid_i && !reg_req_i.write && reg_req_i.addr == a;
  endsequence
  sequence key_wr_s;
    reg_valid_i && reg_req_i.write && reg_req_i.addr == ADDR_HEADSET_KEY;
  endsequence
  ack_one_a: assert property (reg_valid_i |=> reg_ack_o) else $error("ack missing");
  ack_cause_a: assert property (reg_ack_o |-> $past(reg_valid_i)) else $error("stray ack");
  latch_rsvd_a: assert property (rd_s(ADDR_EVENT_LATCH) |=> (reg_rdata_o & 8'hF6) == 8'h00)
    else $error("latch reserved bits set");
  unmapped_rd_a: assert property (rd_s(ADDR_VENDOR_HI) |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  boost_map_a: assert property (hs_boost_tenths_o == (hs_amplitude_trim_o == 2'h0 ? 7'h00 :
    hs_amplitude_trim_o == 2'h1 ? 7'h6F : hs_amplitude_trim_o == 2'h2 ? 7'h4A : 7'h25)) else $error("boost map");
  key_on_a: assert property (key_wr_s ##0 reg_req_i.wdata[3:0] == 4'hA |-> ##2 headset_audio_en_o)
    else $error("headset not enabled");
  key_off_a: assert property (key_wr_s ##0 reg_req_i.wdata[3:0] != 4'hA |-> ##2 !headset_audio_en_o)
    else $error("headset enabled by wrong key");
  conv_len_a: assert property ($fell(converter_run_o) |-> run_cnt_q == CONV_CYCLES_P)
    else $error("conversion length");
  done_after_a: assert property ($fell(converter_run_o) |-> ##[0:3] carkit_res_status_o.done)
    else $error("done not raised");
  status_keep_a: assert property (carkit_res_status_o.done && carkit_status_read_i && !reg_valid_i &&
    !$past(reg_valid_i) |=> carkit_res_status_o.done) else $error("status read cleared done");
  id_irq_a: assert property ($rose(id_floating_i) && id_float_rise_irq_enable_i |-> ##[1:4] alt_int_o)
    else $error("id interrupt missing");
endmodule : id_vendor_props

// *** verif/ulpi_link_model.sv ***
// link-side model issuing immediate register accesses
// assumes one access at a time, answered one cycle after the request edge
`timescale 1ns/1ns
module ulpi_link_model
  import id_vendor_pkg::*;
(
  // clock
  input wire logic clk_i,
  // answer
  input wire logic ack_i,
  input wire logic [7:0] rdata_i,
  // request
  output logic valid_o,
  output reg_req_t req_o
);
  initial begin
    valid_o = 1'b0;
    req_o = '0;
  end
  task automatic access(input logic wr, input logic [5:0] a, input logic [7:0] d,
                        output logic [7:0] rd, output logic ok);
    int n;
    n = 0;
    @(posedge clk_i);
    valid_o <= 1'b1;
    // reserved bit kept clear on conversion register writes
    req_o <= {wr, a, (a == ADDR_RCONV_WR || a == ADDR_RCONV_SET) ? (d & 8'hDF) : d};
    @(posedge clk_i);
    valid_o <= 1'b0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 4);
    ok = (ack_i === 1'b1);
    rd = rdata_i;
    // released request shows no stale value
    req_o <= ~req_o;
  endtask : access
endmodule : ulpi_link_model

// *** verif/id_detect_vendor_regs_tb.sv ***
// self-checking bench for the id-detect and vendor register bank
// assumes the link model drives the register bus; conversion shortened to 20 cycles
`timescale 1ns/1ns
module id_detect_vendor_regs_tb;
  import id_vendor_pkg::*;
  localparam int CONV_P = 20;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic reg_valid_i;
  reg_req_t reg_req_i;
  logic reg_ack_o;
  logic [7:0] reg_rdata_o;
  logic id_floating_i = 1'b0;
  logic id_float_rise_irq_enable_i = 1'b0;
  logic id_float_fall_irq_enable_i = 1'b0;
  logic carkit_resistor_irq_enable_i = 1'b0;
  logic carkit_status_read_i = 1'b0;
  logic [2:0] converter_code_i = 3'h0;
  logic converter_run_o;
  logic [1:0] hs_amplitude_trim_o;
  logic [6:0] hs_boost_tenths_o;
  logic headset_audio_en_o;
  res_status_t carkit_res_status_o;
  logic alt_int_o;
  int n_fail = 0;
  int comparisons = 0;
  int n_int = 0;
  int exp_int = 0;
  int cyc = 0;
  int seed = 31240;
  int m_conv = 0;
  int v;
  int code;
  int boost_t[4] = '{0, 111, 74, 37};
  logic [7:0] rd;
  logic ok;

  id_detect_vendor_regs #(.CONV_CYCLES_P(CONV_P)) dut (.clk_i, .rst_n_i, .reg_valid_i, .reg_req_i,
    .reg_ack_o, .reg_rdata_o, .id_floating_i, .id_float_rise_irq_enable_i, .id_float_fall_irq_enable_i,
    .carkit_resistor_irq_enable_i, .carkit_status_read_i, .converter_code_i, .converter_run_o,
    .hs_amplitude_trim_o, .hs_boost_tenths_o, .headset_audio_en_o, .carkit_res_status_o, .alt_int_o);
  ulpi_link_model lm (.clk_i(clk_i), .ack_i(reg_ack_o), .rdata_i(reg_rdata_o), .valid_o(reg_valid_i),
    .req_o(reg_req_i));

  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (alt_int_o === 1'b1) n_int++;
    if (cyc == 5000) begin
      n_fail++;
      finish_test();
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic rw(input logic wr, input logic [5:0] a, input logic [7:0] d);
    lm.access(wr, a, d, rd, ok);
    check("ack", {7'h00, ok}, 8'h01);
  endtask : rw
  task automatic rdchk(input string what, input logic [5:0] a, input int exp);
    rw(1'b0, a, 8'h00);
    check(what, rd, exp[7:0]);
  endtask : rdchk
  task automatic idset(input logic r, input logic f, input logic l);
    @(posedge clk_i);
    id_float_rise_irq_enable_i <= r;
    id_float_fall_irq_enable_i <= f;
    repeat (2) @(posedge clk_i);
    id_floating_i <= l;
    repeat (6) @(posedge clk_i);
  endtask : idset
  task automatic finish_test();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    int n;
    logic [5:0] addrs[8] = '{6'h21, 6'h31, 6'h33, 6'h36, 6'h37, 6'h38, 6'h30, 6'h3F};
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    foreach (addrs[i]) rdchk("reset read", addrs[i], 0);
    check("reset status", {4'h0, carkit_res_status_o}, 8'h00);
    $display("test reset done");
    for (int t = 0; t < 4; t++) begin
      v = $random(seed);
      rw(1'b1, ADDR_AMP_TRIM, {v[7], t[1:0], v[4:0]});
      rdchk("trim read", ADDR_AMP_TRIM, t << 5);
      check("trim out", {6'h00, hs_amplitude_trim_o}, t[7:0]);
      check("boost", {1'b0, hs_boost_tenths_o}, boost_t[t][7:0]);
    end
    for (int k = 0; k < 16; k++) begin
      v = $random(seed);
      rw(1'b1, ADDR_HEADSET_KEY, {v[3:0], k[3:0]});
      rdchk("key read", ADDR_HEADSET_KEY, k);
      check("headset", {7'h00, headset_audio_en_o}, {7'h00, k == 10});
    end
    rw(1'b1, ADDR_EVENT_LATCH, 8'hFF);
    rdchk("latch ro", ADDR_EVENT_LATCH, 0);
    $display("test registers done");
    idset(1'b1, 1'b0, 1'b1);
    idset(1'b1, 1'b0, 1'b0);
    rdchk("latch id", ADDR_EVENT_LATCH, 1);
    rdchk("latch cleared", ADDR_EVENT_LATCH, 0);
    idset(1'b0, 1'b1, 1'b1);
    idset(1'b0, 1'b1, 1'b0);
    rdchk("latch id", ADDR_EVENT_LATCH, 1);
    exp_int = 2;
    check("id irqs", n_int[7:0], 8'h02);
    $display("test id events done");
    for (int e = 0; e < 3; e++) begin
      code = $random(seed) & 7;
      if (code == 6) code = 5;
      @(posedge clk_i);
      converter_code_i <= code[2:0];
      carkit_resistor_irq_enable_i <= (e == 1);
      if (e == 0) begin
        rw(1'b1, ADDR_RCONV_SET, 8'h50);
        m_conv = m_conv | 8'h50;
      end else if (e == 1) begin
        rw(1'b1, ADDR_RCONV_WR, 8'h30);
        m_conv = 8'h10;
      end else begin
        rw(1'b1, ADDR_RCONV_SET, 8'h40);
        m_conv = m_conv | 8'h40;
        rdchk("conv set", ADDR_RCONV_CLR, m_conv);
        rw(1'b1, ADDR_RCONV_CLR, 8'h40);
        m_conv = m_conv & 8'hBF;
        rw(1'b1, ADDR_RCONV_SET, 8'h10);
        m_conv = m_conv | 8'h10;
        rdchk("conv busy", ADDR_RCONV_WR, m_conv);
      end
      n = 0;
      while (converter_run_o !== 1'b1 && n < 5) begin
        @(posedge clk_i);
        n++;
      end
      n = 0;
      while (converter_run_o === 1'b1 && n < 1000) begin
        @(posedge clk_i);
        n++;
      end
      if (e < 2) check("run length", n[7:0], CONV_P[7:0]);
      repeat (4) @(posedge clk_i);
      m_conv = (m_conv & 8'hE8) | code;
      exp_int += (e < 2);
      check("status", {4'h0, carkit_res_status_o}, {4'h0, 1'b1, code[2:0]});
      @(posedge clk_i);
      carkit_status_read_i <= 1'b1;
      @(posedge clk_i);
      carkit_status_read_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      check("status kept", {7'h00, carkit_res_status_o.done}, 8'h01);
      rdchk("conv done", ADDR_RCONV_WR + e[5:0], m_conv | 8);
      rdchk("conv cleared", ADDR_RCONV_WR, m_conv);
      check("status done", {7'h00, carkit_res_status_o.done}, 8'h00);
      rdchk("latch conv", ADDR_EVENT_LATCH, (e < 2) ? 8 : 0);
      check("conv irqs", n_int[7:0], exp_int[7:0]);
    end
    $display("test conversion done");
    finish_test();
  end
endmodule : id_detect_vendor_regs_tb

bind id_detect_vendor_regs id_vendor_props #(.CONV_CYCLES_P(CONV_CYCLES_P)) u_props (.clk_i, .rst_n_i,
  .reg_valid_i, .reg_req_i, .reg_ack_o, .reg_rdata_o, .id_floating_i, .id_float_rise_irq_enable_i,
  .carkit_status_read_i, .converter_run_o, .hs_amplitude_trim_o, .hs_boost_tenths_o, .headset_audio_en_o,
  .carkit_res_status_o, .alt_int_o);
